// File: hdl/mcuid_pkg.sv
// Package for the instruction decoder: encodings, AHB map and carriers
package mcuid_pkg;
   // Instruction classes (bits 13:12)
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_BRANCH = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;
   // Byte-oriented operation field (bits 11:8)
   localparam logic [3:0] OP_AND_FILE = 4'h5;
   localparam logic [3:0] OP_OR_FILE = 4'h4;
   localparam logic [3:0] OP_XOR_FILE = 4'h6;
   localparam logic [3:0] OP_ADD_FILE = 4'h7;
   localparam logic [3:0] OP_ROT_LEFT = 4'hd;
   localparam logic [3:0] OP_ROT_RIGHT = 4'hc;
   localparam logic [3:0] OP_DEC_SKIP = 4'hb;
   localparam logic [3:0] OP_INC_SKIP = 4'hf;
   // Bit-oriented operation code (bits 11:10)
   localparam logic [1:0] BOP_CLEAR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   localparam logic [1:0] BOP_SKIP_CLR = 2'h2;
   localparam logic [1:0] BOP_SKIP_SET = 2'h3;
   // Literal operation field (bits 11:8), x bits masked
   localparam logic [3:0] LOP_AND = 4'h9;
   localparam logic [3:0] LOP_OR = 4'h8;
   localparam logic [3:0] LOP_XOR = 4'ha;
   localparam logic [2:0] LOP_ADD3 = 3'h7;
   localparam logic [2:0] LOP_SUB3 = 3'h6;
   localparam logic [1:0] LOP_RETLIT2 = 2'h1;
   localparam logic [1:0] LOP_MOVE2 = 2'h0;
   // Fixed control words
   localparam logic [13:0] W_STANDBY = 14'h0063;
   localparam logic [13:0] W_WDT_CLEAR = 14'h0064;
   localparam logic [13:0] W_RETURN = 14'h0008;
   localparam logic [13:0] W_INT_RETURN = 14'h0009;
   localparam logic [13:0] W_NO_OP_MASK = 14'h3f9f;
   localparam logic [13:0] W_NO_OP = 14'h0000;
   // Timing
   localparam int OSC_PER_CYCLE = 4;
   localparam logic [7:0] ADDR_TIMER_ZERO = 8'h01;
   // AHB register map (byte addresses)
   localparam logic [7:0] A_INSTR = 8'h00;
   localparam logic [7:0] A_ACC = 8'h04;
   localparam logic [7:0] A_FILE_IN = 8'h08;
   localparam logic [7:0] A_STATUS = 8'h0c;
   localparam logic [7:0] A_RESULT = 8'h10;
   localparam logic [7:0] A_CONTROL = 8'h14;
   // Status field positions
   localparam int ST_CARRY = 0;
   localparam int ST_HALF = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_PWRDN = 3;
   localparam int ST_TIMEOUT = 4;
   localparam int ST_BUSY = 5;
   localparam int ST_STANDBY = 6;
   localparam logic [4:0] STATUS_RST = 5'h18;

   typedef struct packed {
      logic file_we;
      logic [6:0] file_addr;
      logic [7:0] file_data;
      logic acc_we;
      logic skip;
      logic pc_load;
      logic push;
      logic pop;
      logic [10:0] target;
      logic prescale_clr;
   } mcuid_exec_s;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOPCYC} mcuid_state_e;
endpackage

// File: hdl/mcuid_core.sv
// Instruction decoder and execution control with AHB-Lite access
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Prefix 00 AND 0101, OR 0100, XOR 0110; bit 7 dest; zero only
// - Rotates 1101 left, 1100 right go through carry; only carry changes
// - Field 1011 decrements, skips when zero costing two cycles, no flags
// - Field 1111 increments, skips when zero costing two cycles, no flags
// - Prefix 01 bit ops; code 10 skips next when selected bit clear
// - Code 11 skips when set; 00 clears, 01 sets bit, no flags
// - Literal add 111x, subtract-from-literal 110x; carry, half, zero
// - Literal AND 1001, OR 1000, XOR 1010 write acc, zero only
// - Return-with-literal 01xx loads acc, returns, takes two cycles
// - Standby word 0x0063 enters standby in a cycle, updates both flags
// - Self-modifying port access uses pin levels, not output latch
// - Writing timer-zero count clears prescaler when assigned to it
// - PC change or true test costs a second cycle run as no-op
// - Destination bit zero writes acc, one writes file register
// - One instruction cycle is four oscillator periods
// - Add 0111 sums acc and file, selected dest, carry half zero
module mcuid_core
   import mcuid_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Port pins sensed for self-modifying access
   input wire logic [7:0] port_pins,
   // Execution outputs
   output mcuid_exec_s exec_out,
   output logic standby_out
);
   logic [13:0] instr_reg;
   logic [7:0] acc_reg;
   logic [7:0] file_in_reg;
   logic [4:0] status_reg;
   logic [15:0] result_reg;
   logic [7:0] port_addr_reg;
   logic prescale_t0_reg;
   logic [7:0] pins_s1_reg;
   logic [7:0] pins_s2_reg;
   logic [1:0] osc_reg;
   logic standby_reg;
   logic [7:0] ahb_addr_reg;
   logic ahb_wr_reg;
   mcuid_state_e state_reg;
   mcuid_exec_s exec_reg;
   logic start;

   // Decode fields
   logic [1:0] cls;
   logic [3:0] op;
   logic dest;
   logic [6:0] faddr;
   logic [2:0] bsel;
   logic [7:0] lit;
   logic [7:0] src;
   logic [8:0] sum;
   logic [4:0] hsum;
   logic [7:0] res;
   logic [4:0] st_next;
   logic wr_file;
   logic wr_acc;
   logic skip;
   logic two_cycle;
   mcuid_exec_s ex_next;

   assign cls = instr_reg[13:12];
   assign op = instr_reg[11:8];
   assign dest = instr_reg[7];
   assign faddr = instr_reg[6:0];
   assign bsel = instr_reg[9:7];
   assign lit = instr_reg[7:0];

   // Pins are asynchronous to the core clock
   always_ff @(posedge clock) begin
      pins_s1_reg <= port_pins;
      pins_s2_reg <= pins_s1_reg;
   end

   // Port register read back from pins, not from its latch
   always_comb begin
      if ({1'b0, faddr} == port_addr_reg) begin
         src = pins_s2_reg;
      end else begin
         src = file_in_reg;
      end
   end

   always_comb begin
      sum = 9'h000;
      hsum = 5'h00;
      res = 8'h00;
      st_next = status_reg;
      wr_file = 1'b0;
      wr_acc = 1'b0;
      skip = 1'b0;
      two_cycle = 1'b0;
      ex_next = '0;
      case (cls)
         CLS_BYTE: begin
            case (op)
               OP_AND_FILE, OP_OR_FILE, OP_XOR_FILE: begin
                  res = (op == OP_AND_FILE) ? (acc_reg & src) :
                     (op == OP_OR_FILE) ? (acc_reg | src) :
                     (acc_reg ^ src);
                  st_next[ST_ZERO] = (res == 8'h00);
                  wr_file = dest;
                  wr_acc = ~dest;
               end
               OP_ADD_FILE: begin
                  sum = {1'b0, acc_reg} + {1'b0, src};
                  hsum = {1'b0, acc_reg[3:0]} + {1'b0, src[3:0]};
                  res = sum[7:0];
                  st_next[ST_CARRY] = sum[8];
                  st_next[ST_HALF] = hsum[4];
                  st_next[ST_ZERO] = (res == 8'h00);
                  wr_file = dest;
                  wr_acc = ~dest;
               end
               OP_ROT_LEFT, OP_ROT_RIGHT: begin
                  if (op == OP_ROT_LEFT) begin
                     res = {src[6:0], status_reg[ST_CARRY]};
                     st_next[ST_CARRY] = src[7];
                  end else begin
                     res = {status_reg[ST_CARRY], src[7:1]};
                     st_next[ST_CARRY] = src[0];
                  end
                  wr_file = dest;
                  wr_acc = ~dest;
               end
               OP_DEC_SKIP, OP_INC_SKIP: begin
                  res = (op == OP_DEC_SKIP) ? (src - 8'h01) :
                     (src + 8'h01);
                  skip = (res == 8'h00);
                  two_cycle = skip;
                  wr_file = dest;
                  wr_acc = ~dest;
               end
               default: begin
                  // Fixed control words under prefix 00
                  if (instr_reg == W_STANDBY || instr_reg == W_WDT_CLEAR)
                  begin
                     st_next[ST_TIMEOUT] = 1'b1;
                     st_next[ST_PWRDN] = (instr_reg == W_WDT_CLEAR);
                  end else if (instr_reg == W_RETURN ||
                     instr_reg == W_INT_RETURN) begin
                     ex_next.pop = 1'b1;
                     ex_next.pc_load = 1'b1;
                     two_cycle = 1'b1;
                  end
               end
            endcase
         end
         CLS_BIT: begin
            res = src;
            case (op[3:2])
               BOP_CLEAR: begin
                  res[bsel] = 1'b0;
                  wr_file = 1'b1;
               end
               BOP_SET: begin
                  res[bsel] = 1'b1;
                  wr_file = 1'b1;
               end
               BOP_SKIP_CLR: skip = ~src[bsel];
               default: skip = src[bsel];
            endcase
            two_cycle = skip;
         end
         CLS_BRANCH: begin
            ex_next.pc_load = 1'b1;
            ex_next.push = ~op[3];
            ex_next.target = instr_reg[10:0];
            two_cycle = 1'b1;
         end
         default: begin
            if (op[3:1] == LOP_ADD3 || op[3:1] == LOP_SUB3) begin
               if (op[3:1] == LOP_ADD3) begin
                  sum = {1'b0, lit} + {1'b0, acc_reg};
                  hsum = {1'b0, lit[3:0]} + {1'b0, acc_reg[3:0]};
               end else begin
                  sum = {1'b0, lit} + {1'b0, ~acc_reg} + 9'h001;
                  hsum = {1'b0, lit[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
               end
               res = sum[7:0];
               st_next[ST_CARRY] = sum[8];
               st_next[ST_HALF] = hsum[4];
               st_next[ST_ZERO] = (res == 8'h00);
               wr_acc = 1'b1;
            end else if (op == LOP_AND || op == LOP_OR || op == LOP_XOR)
            begin
               res = (op == LOP_AND) ? (acc_reg & lit) :
                  (op == LOP_OR) ? (acc_reg | lit) :
                  (acc_reg ^ lit);
               st_next[ST_ZERO] = (res == 8'h00);
               wr_acc = 1'b1;
            end else if (op[3:2] == LOP_RETLIT2) begin
               res = lit;
               wr_acc = 1'b1;
               ex_next.pop = 1'b1;
               ex_next.pc_load = 1'b1;
               two_cycle = 1'b1;
            end else if (op[3:2] == LOP_MOVE2) begin
               res = lit;
               wr_acc = 1'b1;
            end
         end
      endcase
      ex_next.file_we = wr_file;
      ex_next.file_addr = faddr;
      ex_next.file_data = res;
      ex_next.acc_we = wr_acc;
      ex_next.skip = skip;
      // Timer-zero write drops the shared prescaler count
      ex_next.prescale_clr = wr_file && ({1'b0, faddr} == ADDR_TIMER_ZERO) &&
         prescale_t0_reg;
   end

   // AHB-Lite: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign start = ahb_wr_reg && (ahb_addr_reg == A_INSTR) &&
      (state_reg == ST_IDLE);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ahb_addr_reg <= 8'h00;
         ahb_wr_reg <= 1'b0;
      end else if (hready) begin
         ahb_addr_reg <= haddr;
         ahb_wr_reg <= hsel && htrans[1] && hwrite;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && htrans[1] && !hwrite && hready) begin
         case (haddr)
            A_INSTR: hrdata <= {18'h0_0000, instr_reg};
            A_ACC: hrdata <= {24'h00_0000, acc_reg};
            A_FILE_IN: hrdata <= {24'h00_0000, file_in_reg};
            A_STATUS: hrdata <= {25'h000_0000, standby_reg,
               state_reg != ST_IDLE, status_reg};
            A_RESULT: hrdata <= {16'h0000, result_reg};
            A_CONTROL: hrdata <= {23'h00_0000, prescale_t0_reg,
               port_addr_reg};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Software-loaded operands and configuration
   always_ff @(posedge clock) begin
      if (!nrst) begin
         instr_reg <= W_NO_OP;
         file_in_reg <= 8'h00;
         port_addr_reg <= 8'hff;
         prescale_t0_reg <= 1'b0;
      end else if (ahb_wr_reg && state_reg == ST_IDLE) begin
         case (ahb_addr_reg)
            A_INSTR: instr_reg <= hwdata[13:0];
            A_FILE_IN: file_in_reg <= hwdata[7:0];
            A_CONTROL: begin
               port_addr_reg <= hwdata[7:0];
               prescale_t0_reg <= hwdata[8];
            end
            default: ;
         endcase
      end
   end

   // Four oscillator periods make one instruction cycle
   always_ff @(posedge clock) begin
      if (!nrst || state_reg == ST_IDLE) begin
         osc_reg <= 2'h0;
      end else begin
         osc_reg <= osc_reg + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: if (start) state_reg <= ST_EXEC;
            ST_EXEC: if (osc_reg == 2'(OSC_PER_CYCLE - 1)) begin
               state_reg <= two_cycle ? ST_NOPCYC : ST_IDLE;
            end
            ST_NOPCYC: if (osc_reg == 2'(OSC_PER_CYCLE - 1)) begin
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Results commit at the end of the first instruction cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         acc_reg <= 8'h00;
         status_reg <= STATUS_RST;
         result_reg <= 16'h0000;
         exec_reg <= '0;
         standby_reg <= 1'b0;
      end else if (state_reg == ST_EXEC &&
         osc_reg == 2'(OSC_PER_CYCLE - 1)) begin
         if (wr_acc) acc_reg <= ex_next.file_data;
         status_reg <= st_next;
         result_reg <= {6'h00, two_cycle, skip, ex_next.file_data};
         exec_reg <= ex_next;
         standby_reg <= (instr_reg == W_STANDBY);
      end else begin
         exec_reg <= '0;
         if (start) standby_reg <= 1'b0;
      end
   end

   assign exec_out = exec_reg;
   assign standby_out = standby_reg;

   a_two_cycle_len: assert property (@(posedge clock)
      disable iff (!nrst) state_reg == ST_NOPCYC &&
      $past(state_reg) == ST_EXEC |-> ##4 state_reg == ST_IDLE)
      else $error("second cycle not four periods");
   a_cycle_len: assert property (@(posedge clock)
      disable iff (!nrst) start |=> state_reg == ST_EXEC [*4])
      else $error("instruction cycle not four periods");
   a_branch_twocyc: assert property (@(posedge clock)
      disable iff (!nrst) exec_reg.pc_load |-> state_reg == ST_NOPCYC)
      else $error("branch without second cycle");
   a_skip_twocyc: assert property (@(posedge clock)
      disable iff (!nrst) exec_reg.skip |-> state_reg == ST_NOPCYC)
      else $error("skip without second cycle");
   a_prescale_clr: assert property (@(posedge clock)
      disable iff (!nrst) exec_reg.prescale_clr |-> exec_reg.file_we &&
      prescale_t0_reg && exec_reg.file_addr == ADDR_TIMER_ZERO[6:0])
      else $error("prescaler clear without timer write");
   a_logic_zero: assert property (@(posedge clock)
      disable iff (!nrst) $past(state_reg) == ST_EXEC &&
      $past(cls) == CLS_LIT && $past(op) == LOP_AND && exec_reg.acc_we
      |-> status_reg[ST_ZERO] == (acc_reg == 8'h00))
      else $error("zero flag wrong after literal and");
   a_standby_flags: assert property (@(posedge clock)
      disable iff (!nrst) $rose(standby_reg) |->
      status_reg[ST_TIMEOUT] && !status_reg[ST_PWRDN])
      else $error("standby flags wrong");
   a_call_push: assert property (@(posedge clock)
      disable iff (!nrst) exec_reg.push |-> exec_reg.pc_load && !exec_reg.pop)
      else $error("push without call");
   c_skip: cover property (@(posedge clock) exec_reg.skip);
   c_call: cover property (@(posedge clock) exec_reg.push);
   c_standby: cover property (@(posedge clock) $rose(standby_reg));
   c_prescale: cover property (@(posedge clock) exec_reg.prescale_clr);
endmodule

// File: bench/mcuid_prog_mem.sv
// Program memory model that hands instruction words to the bench
`timescale 1ns/100ps
module mcuid_prog_mem (
   // Clock
   input wire logic clock,
   // Load port
   input wire logic load_en,
   input wire logic [5:0] load_addr,
   input wire logic [13:0] load_word,
   // Fetch port, one cycle of read latency
   input wire logic fetch_en,
   input wire logic [5:0] fetch_addr,
   output logic [13:0] fetch_word
);
   logic [13:0] mem_reg [64];

   always_ff @(posedge clock) begin
      if (load_en) begin
         mem_reg[load_addr] <= load_word;
      end
   end

   // Between fetches the word toggles so a stale read cannot pass
   always_ff @(posedge clock) begin
      if (fetch_en) begin
         fetch_word <= mem_reg[fetch_addr];
      end else begin
         fetch_word <= ~fetch_word;
      end
   end
endmodule

// File: bench/tb_mcuid_core.sv
// Self-checking bench for the instruction decoder core
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_mcuid_core;
   import mcuid_pkg::*;
   // Row: word, acc, file operand, result, {check, two, skip}, ZDC C, we
   typedef struct packed {
      logic [13:0] instr;
      logic [7:0] acc;
      logic [7:0] fin;
      logic [7:0] res;
      logic [2:0] cst;
      logic [2:0] flg;
      logic [1:0] we;
   } mcuid_row_s;
   localparam int NR = 28;
   mcuid_row_s rows [NR] = '{
      '{14'h0520,8'h0f,8'hf0,8'h00,3'h4,3'h4,2'h1},
      '{14'h04a1,8'h0f,8'hf0,8'hff,3'h4,3'h0,2'h2},
      '{14'h0622,8'haa,8'haa,8'h00,3'h4,3'h4,2'h1},
      '{14'h07a3,8'h88,8'h88,8'h10,3'h4,3'h3,2'h2},
      '{14'h0d24,8'h00,8'h81,8'h03,3'h4,3'h3,2'h1},
      '{14'h0ca5,8'h00,8'h02,8'h81,3'h4,3'h2,2'h2},
      '{14'h0b26,8'h00,8'h01,8'h00,3'h7,3'h2,2'h1},
      '{14'h0ba6,8'h00,8'h05,8'h04,3'h4,3'h2,2'h2},
      '{14'h0fa7,8'h00,8'hff,8'h00,3'h7,3'h2,2'h2},
      '{14'h0f27,8'h00,8'h10,8'h11,3'h4,3'h2,2'h1},
      '{14'h13a8,8'h00,8'hff,8'h7f,3'h4,3'h2,2'h2},
      '{14'h1428,8'h00,8'h00,8'h01,3'h4,3'h2,2'h2},
      '{14'h19a8,8'h00,8'hf7,8'h00,3'h3,3'h2,2'h0},
      '{14'h19a8,8'h00,8'h08,8'h00,3'h0,3'h2,2'h0},
      '{14'h1ea8,8'h00,8'h20,8'h00,3'h3,3'h2,2'h0},
      '{14'h1ea8,8'h00,8'hdf,8'h00,3'h0,3'h2,2'h0},
      '{14'h3f01,8'h0f,8'h00,8'h10,3'h4,3'h2,2'h1},
      '{14'h3d01,8'h01,8'h00,8'h00,3'h4,3'h7,2'h1},
      '{14'h3c01,8'h02,8'h00,8'hff,3'h4,3'h0,2'h1},
      '{14'h39f0,8'h0f,8'h00,8'h00,3'h4,3'h4,2'h1},
      '{14'h3880,8'h01,8'h00,8'h81,3'h4,3'h0,2'h1},
      '{14'h3a55,8'h55,8'h00,8'h00,3'h4,3'h4,2'h1},
      '{14'h37a5,8'h00,8'h00,8'ha5,3'h6,3'h4,2'h1},
      '{14'h2923,8'h00,8'h00,8'h00,3'h2,3'h4,2'h0},
      '{14'h27ff,8'h00,8'h00,8'h00,3'h2,3'h4,2'h0},
      '{14'h0008,8'h00,8'h00,8'h00,3'h2,3'h4,2'h0},
      '{14'h0009,8'h00,8'h00,8'h00,3'h2,3'h4,2'h0},
      '{14'h0060,8'h00,8'h00,8'h00,3'h0,3'h4,2'h0}};
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [7:0] port_pins = 8'h00;
   logic hreadyout, hresp, standby_out;
   logic [31:0] hrdata;
   mcuid_exec_s exec_out, lx;
   logic pm_ld = 1'b0;
   logic pm_fe = 1'b0;
   logic [5:0] pm_la = 6'h00;
   logic [5:0] pm_fa = 6'h00;
   logic [13:0] pm_lw = 14'h0000;
   logic [13:0] pm_w;
   int failures = 0;
   int cmp_count = 0;

   always #12.5 clock = ~clock;

   mcuid_core dut_u (.clock(clock), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .port_pins(port_pins),
      .exec_out(exec_out), .standby_out(standby_out));
   mcuid_prog_mem pm_u (.clock(clock), .load_en(pm_ld),
      .load_addr(pm_la), .load_word(pm_lw), .fetch_en(pm_fe),
      .fetch_addr(pm_fa), .fetch_word(pm_w));

   // Keep the last commit pulse, it stands for one cycle only
   always @(posedge clock) begin
      if (|exec_out) begin
         lx <= exec_out;
      end else if (hsel && htrans[1] && hwrite && haddr == A_INSTR) begin
         lx <= '0;
      end
   end

   task automatic end_sim;
      if (failures == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic wt_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         failures++;
         end_sim;
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wt_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt_rdy;
      q = hrdata;
      `CHK(hresp, 1'b0)
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic idle;
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         rd(A_STATUS, q);
         n++;
      end while (q[ST_BUSY] !== 1'b0 && n < 20);
      if (q[ST_BUSY] !== 1'b0) begin
         failures++;
         end_sim;
      end
   endtask

   task automatic run(input logic [13:0] w);
      wr(A_INSTR, {18'h0, w});
      idle;
   endtask

   // Commit pulse timing, then the extra no-op cycle of two-cycle ops
   task automatic timed(input logic [13:0] w, input logic two,
         output int n);
      logic [31:0] q;
      wr(A_INSTR, {18'h0, w});
      n = 0;
      while (!(|exec_out) && n < 20) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20) begin
         failures++;
         end_sim;
      end
      @(posedge clock);
      `CHK(|exec_out, 1'b0)
      rd(A_STATUS, q);
      `CHK(q[ST_BUSY], two)
      repeat (4) @(posedge clock);
      rd(A_STATUS, q);
      `CHK(q[ST_BUSY], 1'b0)
   endtask

   initial begin
      logic [31:0] q;
      int l1, l2;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      `CHK(hrdata, 32'h0000_0000)
      `CHK(|exec_out, 1'b0)
      rd(A_STATUS, q);
      `CHK(q, 32'h0000_0018)
      rd(A_CONTROL, q);
      `CHK(q, 32'h0000_00ff)
      rd(8'h18, q);
      `CHK(q, 32'h0000_0000)
      wr(A_FILE_IN, 32'h0000_00a5);
      rd(A_FILE_IN, q);
      `CHK(q, 32'h0000_00a5)
      for (int i = 0; i < NR; i++) begin
         pm_ld <= 1'b1;
         pm_la <= 6'(i);
         pm_lw <= rows[i].instr;
         @(posedge clock);
      end
      pm_ld <= 1'b0;
      for (int i = 0; i < NR; i++) begin
         run({6'h30, rows[i].acc});
         wr(A_FILE_IN, {24'h00_0000, rows[i].fin});
         pm_fe <= 1'b1;
         pm_fa <= 6'(i);
         @(posedge clock);
         pm_fe <= 1'b0;
         @(posedge clock);
         run(pm_w);
         rd(A_RESULT, q);
         if (rows[i].cst[2]) `CHK(q[7:0], rows[i].res)
         `CHK(q[9:8], rows[i].cst[1:0])
         `CHK(lx.skip, rows[i].cst[0])
         `CHK(lx.file_we, rows[i].we[1])
         `CHK(lx.acc_we, rows[i].we[0])
         if (rows[i].we[1]) `CHK(lx.file_addr, rows[i].instr[6:0])
         if (rows[i].we[1]) `CHK(lx.file_data, rows[i].res)
         rd(A_STATUS, q);
         `CHK(q[2:0], rows[i].flg)
      end
      run(14'h2923);
      `CHK(lx.pc_load, 1'b1)
      `CHK(lx.target, 11'h123)
      run(14'h27ff);
      `CHK(lx.push, 1'b1)
      `CHK(lx.target, 11'h7ff)
      run(W_RETURN);
      `CHK(lx.pop, 1'b1)
      run(14'h37a5);
      `CHK(lx.pop, 1'b1)
      // Self-modifying access to the port reads the pins
      port_pins <= 8'h5a;
      wr(A_CONTROL, 32'h0000_0030);
      run(14'h3000);
      wr(A_FILE_IN, 32'h0000_0000);
      run(14'h04b0);
      rd(A_RESULT, q);
      `CHK(q[7:0], 8'h5a)
      run(14'h04b1);
      rd(A_RESULT, q);
      `CHK(q[7:0], 8'h00)
      for (int i = 0; i < 3; i++) begin
         wr(A_CONTROL, (i == 1) ? 32'h0000_00ff : 32'h0000_01ff);
         run((i == 2) ? 14'h0401 : 14'h0481);
         `CHK(lx.prescale_clr, i == 0)
      end
      timed(14'h3000, 1'b0, l1);
      timed(14'h2923, 1'b1, l2);
      `CHK(l1, l2)
      `CHK(l1, OSC_PER_CYCLE + 1)
      // A second start while busy is dropped
      wr(A_INSTR, 32'h0000_3011);
      wr(A_INSTR, 32'h0000_3022);
      idle;
      rd(A_ACC, q);
      `CHK(q[7:0], 8'h11)
      run(W_STANDBY);
      rd(A_STATUS, q);
      `CHK(standby_out, 1'b1)
      `CHK(q[6:3], 4'ha)
      run(W_WDT_CLEAR);
      rd(A_STATUS, q);
      `CHK(standby_out, 1'b0)
      `CHK(q[6:3], 4'h3)
      run(W_STANDBY);
      nrst <= 1'b0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      `CHK(standby_out, 1'b0)
      rd(A_STATUS, q);
      `CHK(q, 32'h0000_0018)
      end_sim;
   end
endmodule
